// file: verilog/rhpd_pkg.sv
// constants for the root hub power descriptor register bank
// assumes an 8-bit command code port with 32-bit data words
package rhpd_pkg;

  localparam int          DATA_W          = 32;
  localparam int          CODE_W          = 8;
  localparam int          NUM_PORTS       = 2;

  // command codes: read and write of each descriptor register
  localparam logic [7:0]  CMD_RD_SWITCH   = 8'h12;
  localparam logic [7:0]  CMD_WR_SWITCH   = 8'h92;
  localparam logic [7:0]  CMD_RD_PORTPWR  = 8'h13;
  localparam logic [7:0]  CMD_WR_PORTPWR  = 8'h93;

  // switching descriptor field positions
  localparam int          SW_NDP_LSB      = 0;
  localparam int          SW_NDP_MSB      = 1;
  localparam int          SW_PSM_BIT      = 8;
  localparam int          SW_NPS_BIT      = 9;
  localparam int          SW_DT_BIT       = 10;
  localparam int          SW_OCPM_BIT     = 11;
  localparam int          SW_NOCP_BIT     = 12;
  localparam int          SW_POTPGT_LSB   = 24;
  localparam int          SW_POTPGT_MSB   = 31;

  // port power descriptor field positions
  localparam int          PP_DR_LSB       = 0;
  localparam int          PP_DR_MSB       = 2;
  localparam int          PP_PPCM_LSB     = 16;
  localparam int          PP_PPCM_MSB     = 18;

  // reset values
  localparam logic [1:0]  RST_NDP         = 2'h2;
  localparam logic        RST_PSM         = 1'b1;
  localparam logic        RST_NPS         = 1'b0;
  localparam logic        RST_OCPM        = 1'b1;
  localparam logic        RST_NOCP        = 1'b0;
  localparam logic [7:0]  RST_POTPGT      = 8'hff;
  localparam logic [2:0]  RST_PPCM        = 3'h0;
  localparam logic [2:0]  RST_DR          = 3'h0;
  // bit 0 of the per-port fields never holds state
  localparam logic [2:0]  PORT_FIELD_MASK = 3'h6;

  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

endpackage

// file: verilog/rhpd_regs.sv
// root hub switching and port power descriptor registers with port power control
// assumes command, data and power command inputs come from logic on CORE_CLK_IN
`timescale 1ns/1ps

module rhpd_regs #(
  parameter logic [2:0] PPCM_RESET = rhpd_pkg::RST_PPCM,
  parameter logic [2:0] DR_RESET   = rhpd_pkg::RST_DR
) (
  input  wire logic                          CORE_CLK_IN,
  input  wire logic                          RST_IN,
  input  wire logic                          CMD_VALID_IN,
  input  wire logic [rhpd_pkg::CODE_W-1:0]   CMD_CODE_IN,
  input  wire logic [rhpd_pkg::DATA_W-1:0]   CMD_WDATA_IN,
  input  wire logic                          GLOBAL_SET_PWR_IN,
  input  wire logic                          GLOBAL_CLR_PWR_IN,
  input  wire logic [rhpd_pkg::NUM_PORTS:1]  PORT_SET_PWR_IN,
  input  wire logic [rhpd_pkg::NUM_PORTS:1]  PORT_CLR_PWR_IN,
  output logic      [rhpd_pkg::DATA_W-1:0]   RDATA_OUT,
  output logic                               RDATA_VALID_OUT,
  output logic      [rhpd_pkg::NUM_PORTS:1]  PORT_POWER_OUT,
  output logic      [rhpd_pkg::NUM_PORTS:1]  DEVICE_REMOVABLE_OUT
);
  import rhpd_pkg::*;

  logic                   power_switch_mode_r;
  logic                   no_power_switching_r;
  logic                   ocp_mode_r;
  logic                   no_ocp_r;
  logic [7:0]             pwr_good_time_r;
  logic [2:0]             port_power_ctrl_mask_r;
  logic [2:0]             device_removable_flags_r;
  logic [NUM_PORTS:1]     port_power_state_r;
  logic [NUM_PORTS:1]     port_power_state_nxt;
  logic [DATA_W-1:0]      switching_desc_word;
  logic [DATA_W-1:0]      port_power_desc_word;
  logic                   wr_switch;
  logic                   wr_portpwr;
  logic                   per_port_mode;

  assign wr_switch  = CMD_VALID_IN && (CMD_CODE_IN == CMD_WR_SWITCH);
  assign wr_portpwr = CMD_VALID_IN && (CMD_CODE_IN == CMD_WR_PORTPWR);

  // mode bit gated by switching present
  assign per_port_mode = power_switch_mode_r && !no_power_switching_r;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      power_switch_mode_r  <= RST_PSM;
      no_power_switching_r <= RST_NPS;
      ocp_mode_r           <= RST_OCPM;
      no_ocp_r             <= RST_NOCP;
      pwr_good_time_r      <= RST_POTPGT;
    end else if (wr_switch) begin
      power_switch_mode_r  <= CMD_WDATA_IN[SW_PSM_BIT];
      no_power_switching_r <= CMD_WDATA_IN[SW_NPS_BIT];
      ocp_mode_r           <= CMD_WDATA_IN[SW_OCPM_BIT];
      no_ocp_r             <= CMD_WDATA_IN[SW_NOCP_BIT];
      pwr_good_time_r      <= CMD_WDATA_IN[SW_POTPGT_MSB:SW_POTPGT_LSB];
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      port_power_ctrl_mask_r   <= PPCM_RESET & PORT_FIELD_MASK;
      device_removable_flags_r <= DR_RESET & PORT_FIELD_MASK;
    end else if (wr_portpwr) begin
      port_power_ctrl_mask_r   <= CMD_WDATA_IN[PP_PPCM_MSB:PP_PPCM_LSB] & PORT_FIELD_MASK;
      device_removable_flags_r <= CMD_WDATA_IN[PP_DR_MSB:PP_DR_LSB] & PORT_FIELD_MASK;
    end
  end

  // per-port power decision; a set and clear together leave the port powered
  always_comb begin
    port_power_state_nxt = port_power_state_r;
    for (int p = 1; p <= NUM_PORTS; p++) begin
      if (no_power_switching_r) begin
        port_power_state_nxt[p] = 1'b1;
      end else if (per_port_mode && port_power_ctrl_mask_r[p]) begin
        if (PORT_SET_PWR_IN[p]) begin
          port_power_state_nxt[p] = 1'b1;
        end else if (PORT_CLR_PWR_IN[p]) begin
          port_power_state_nxt[p] = 1'b0;
        end
      end else begin
        if (GLOBAL_SET_PWR_IN) begin
          port_power_state_nxt[p] = 1'b1;
        end else if (GLOBAL_CLR_PWR_IN) begin
          port_power_state_nxt[p] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      port_power_state_r <= '0;
    end else begin
      port_power_state_r <= port_power_state_nxt;
    end
  end

  always_comb begin
    switching_desc_word                              = ZERO_WORD;
    switching_desc_word[SW_NDP_MSB:SW_NDP_LSB]       = RST_NDP;
    switching_desc_word[SW_PSM_BIT]                  = power_switch_mode_r;
    switching_desc_word[SW_NPS_BIT]                  = no_power_switching_r;
    switching_desc_word[SW_DT_BIT]                   = 1'b0;
    switching_desc_word[SW_OCPM_BIT]                 = ocp_mode_r;
    switching_desc_word[SW_NOCP_BIT]                 = no_ocp_r;
    switching_desc_word[SW_POTPGT_MSB:SW_POTPGT_LSB] = pwr_good_time_r;
    port_power_desc_word                             = ZERO_WORD;
    port_power_desc_word[PP_PPCM_MSB:PP_PPCM_LSB]    = port_power_ctrl_mask_r;
    port_power_desc_word[PP_DR_MSB:PP_DR_LSB]        = device_removable_flags_r;
  end

  // reads answer one cycle after the code; unknown codes give no answer
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      RDATA_OUT       <= ZERO_WORD;
      RDATA_VALID_OUT <= 1'b0;
    end else begin
      RDATA_VALID_OUT <= 1'b0;
      if (CMD_VALID_IN && (CMD_CODE_IN == CMD_RD_SWITCH)) begin
        RDATA_OUT       <= switching_desc_word;
        RDATA_VALID_OUT <= 1'b1;
      end else if (CMD_VALID_IN && (CMD_CODE_IN == CMD_RD_PORTPWR)) begin
        RDATA_OUT       <= port_power_desc_word;
        RDATA_VALID_OUT <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      PORT_POWER_OUT       <= '0;
      DEVICE_REMOVABLE_OUT <= '0;
    end else begin
      PORT_POWER_OUT       <= port_power_state_nxt;
      DEVICE_REMOVABLE_OUT <= device_removable_flags_r[NUM_PORTS:1];
    end
  end

endmodule

// file: verification/rhpd_regs_chk.sv
// assertions on the root hub power descriptor bank ports
// assumes mode writes never share a cycle with power commands
`timescale 1ns/1ps
module rhpd_chk
  import rhpd_pkg::*;
(
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_IN,
  input wire logic        CMD_VALID_IN,
  input wire logic [7:0]  CMD_CODE_IN,
  input wire logic [31:0] CMD_WDATA_IN,
  input wire logic        GLOBAL_SET_PWR_IN,
  input wire logic        GLOBAL_CLR_PWR_IN,
  input wire logic [2:1]  PORT_SET_PWR_IN,
  input wire logic [2:1]  PORT_CLR_PWR_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        RDATA_VALID_OUT,
  input wire logic [2:1]  PORT_POWER_OUT
);
  logic       nps_r;
  logic       psm_r;
  logic [2:1] msk_r;
  wire        go  = CMD_VALID_IN;
  wire        rd  = go && (CMD_CODE_IN == CMD_RD_SWITCH || CMD_CODE_IN == CMD_RD_PORTPWR);
  wire        ind = !nps_r && psm_r;
  wire        gcm = GLOBAL_SET_PWR_IN || GLOBAL_CLR_PWR_IN;
  // mirror of the mode bits, since the checker sees only ports
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      nps_r <= RST_NPS;
      psm_r <= RST_PSM;
    end else if (go && CMD_CODE_IN == CMD_WR_SWITCH) begin
      nps_r <= CMD_WDATA_IN[SW_NPS_BIT];
      psm_r <= CMD_WDATA_IN[SW_PSM_BIT];
    end
  end
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN)
      msk_r <= 2'h0;
    else if (go && CMD_CODE_IN == CMD_WR_PORTPWR)
      msk_r <= CMD_WDATA_IN[18:17];
  end
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  a_read_answer_lat: assert property (rd |=> RDATA_VALID_OUT)
    else $error("read answer missing");
  a_answer_has_cause: assert property (RDATA_VALID_OUT |-> $past(rd))
    else $error("read answer without read");
  a_port_rsv_zero: assert property (RDATA_VALID_OUT && $past(CMD_CODE_IN) == CMD_RD_PORTPWR
    |-> (RDATA_OUT & 32'hfff9_fff9) == 32'h0)
    else $error("port descriptor reserved bits set");
  a_switch_fixed_fld: assert property (RDATA_VALID_OUT && $past(CMD_CODE_IN) == CMD_RD_SWITCH
    |-> (RDATA_OUT & 32'h00ff_e4ff) == 32'h2)
    else $error("switch descriptor fixed fields wrong");
  a_nps_all_on: assert property (nps_r |=> PORT_POWER_OUT == 2'h3)
    else $error("ports not held powered");
  a_gang_global_set: assert property (!nps_r && !psm_r && GLOBAL_SET_PWR_IN
    |=> PORT_POWER_OUT == 2'h3)
    else $error("ganged set missed a port");
  a_gang_port_ignored: assert property (!nps_r && !psm_r && !gcm |=> $stable(PORT_POWER_OUT))
    else $error("ganged mode moved on port command");
  a_masked_no_global: assert property (ind && msk_r[1] && PORT_SET_PWR_IN[1] == 1'b0
    && PORT_CLR_PWR_IN[1] == 1'b0 |=> $stable(PORT_POWER_OUT[1]))
    else $error("masked port moved");
  a_unmasked_no_port: assert property (ind && !msk_r[2] && !gcm
    |=> $stable(PORT_POWER_OUT[2]))
    else $error("unmasked port took port command");
endmodule
bind rhpd_regs rhpd_chk u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
  .CMD_VALID_IN(CMD_VALID_IN), .CMD_CODE_IN(CMD_CODE_IN), .CMD_WDATA_IN(CMD_WDATA_IN),
  .GLOBAL_SET_PWR_IN(GLOBAL_SET_PWR_IN), .GLOBAL_CLR_PWR_IN(GLOBAL_CLR_PWR_IN),
  .PORT_SET_PWR_IN(PORT_SET_PWR_IN), .PORT_CLR_PWR_IN(PORT_CLR_PWR_IN),
  .RDATA_OUT(RDATA_OUT), .RDATA_VALID_OUT(RDATA_VALID_OUT), .PORT_POWER_OUT(PORT_POWER_OUT));

// file: verification/test_root_hub_power_descriptor_regs.sv
// self-checking bench for the root hub power descriptor bank
// assumes the design alone drives read data and port power
`timescale 1ns/1ps
module test_root_hub_power_descriptor_regs;
  import rhpd_pkg::*;
  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  logic        vld         = 1'b0;
  logic [7:0]  code        = 8'h00;
  logic [31:0] wd          = 32'h0;
  logic        gs          = 1'b0;
  logic        gc          = 1'b0;
  logic [2:1]  ps          = 2'h0;
  logic [2:1]  pc          = 2'h0;
  logic [31:0] rdata;
  logic        rvld;
  logic [2:1]  pwr;
  logic [2:1]  rem;
  int          miscompares = 0;
  int          checks      = 0;
  always #2.5 clk = ~clk;
  rhpd_regs dut (.CORE_CLK_IN(clk), .RST_IN(rst), .CMD_VALID_IN(vld), .CMD_CODE_IN(code),
    .CMD_WDATA_IN(wd), .GLOBAL_SET_PWR_IN(gs), .GLOBAL_CLR_PWR_IN(gc), .PORT_SET_PWR_IN(ps),
    .PORT_CLR_PWR_IN(pc), .RDATA_OUT(rdata), .RDATA_VALID_OUT(rvld), .PORT_POWER_OUT(pwr),
    .DEVICE_REMOVABLE_OUT(rem));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] d);
    @(posedge clk);
    vld  <= 1'b1;
    code <= c;
    wd   <= d;
    @(posedge clk);
    vld  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] c, input logic [31:0] exp);
    cmd(c, 32'h0);
    #1;
    chk({31'h0, rvld}, 32'h1);
    chk(rdata, exp);
  endtask
  // one power pulse, then the settled state is compared
  task automatic pw(input logic s, input logic c, input logic [2:1] p_s, input logic [2:1] p_c,
                    input logic [2:1] exp);
    @(posedge clk);
    gs <= s;
    gc <= c;
    ps <= p_s;
    pc <= p_c;
    @(posedge clk);
    gs <= 1'b0;
    gc <= 1'b0;
    ps <= 2'h0;
    pc <= 2'h0;
    @(posedge clk);
    #1;
    chk({30'h0, pwr}, {30'h0, exp});
  endtask
  task automatic t_reset;
    rd(CMD_RD_SWITCH, 32'hff00_0902);
    rd(CMD_RD_PORTPWR, 32'h0);
    chk({30'h0, pwr}, 32'h0);
  endtask
  task automatic t_regs;
    cmd(CMD_WR_PORTPWR, 32'hffff_ffff);
    cmd(8'h14, 32'h0);
    rd(CMD_RD_PORTPWR, 32'h0006_0006);
    chk({30'h0, rem}, 32'h3);
    cmd(CMD_WR_SWITCH, 32'hffff_ffff);
    rd(CMD_RD_SWITCH, 32'hff00_1b02);
    pw(1'b0, 1'b1, 2'h0, 2'h3, 2'h3);
  endtask
  task automatic t_gang;
    cmd(CMD_WR_SWITCH, 32'h0);
    pw(1'b0, 1'b1, 2'h0, 2'h0, 2'h0);
    pw(1'b0, 1'b0, 2'h3, 2'h0, 2'h0);
    pw(1'b1, 1'b0, 2'h0, 2'h0, 2'h3);
  endtask
  task automatic t_indiv;
    cmd(CMD_WR_SWITCH, 32'h100);
    cmd(CMD_WR_PORTPWR, 32'h0005_0000);
    pw(1'b0, 1'b1, 2'h0, 2'h0, 2'h2);
    pw(1'b0, 1'b0, 2'h1, 2'h0, 2'h2);
    pw(1'b0, 1'b0, 2'h0, 2'h2, 2'h0);
    pw(1'b1, 1'b0, 2'h0, 2'h0, 2'h1);
    cmd(CMD_WR_PORTPWR, 32'h0002_0000);
    pw(1'b0, 1'b1, 2'h0, 2'h0, 2'h1);
    pw(1'b0, 1'b0, 2'h2, 2'h0, 2'h1);
    pw(1'b0, 1'b0, 2'h0, 2'h1, 2'h0);
    pw(1'b1, 1'b0, 2'h0, 2'h0, 2'h2);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_gang();
    t_indiv();
    finish_test();
  end
  // the sequence needs about 75 cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule
